//--- logic/ppess_pkg.sv
// Constants for the period event source select block.
// Assumes an 8-bit register port with one-cycle strobes.
package ppess_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int TB_W   = 16;
    localparam int SRC_N  = 4;
    // Register offsets
    localparam logic [3:0] OFF_PERIOD_SRC  = 4'h0;
    localparam logic [3:0] OFF_FALL_SRC    = 4'h1;
    localparam logic [3:0] OFF_PERIOD_LO   = 4'h2;
    localparam logic [3:0] OFF_PERIOD_HI   = 4'h3;
    localparam logic [3:0] OFF_DUTY_LO     = 4'h4;
    localparam logic [3:0] OFF_DUTY_HI     = 4'h5;
    localparam logic [3:0] OFF_TIMEBASE_LO = 4'h6;
    localparam logic [3:0] OFF_TIMEBASE_HI = 4'h7;
    // Source enable field layout, shared by both source registers
    localparam int BIT_TIMEBASE = 0;
    localparam int BIT_CMP1     = 1;
    localparam int BIT_CMP2     = 2;
    localparam int BIT_CMP3     = 3;
    localparam int BIT_PIN      = 7;
    localparam logic [7:0] SRC_IMPL_MASK = 8'h8F;
    // Reset values
    localparam logic [7:0]  SRC_RESET    = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] DUTY_RESET   = 16'h0000;
    localparam logic [15:0] TB_RESET     = 16'h0000;
    localparam logic [15:0] TB_STEP      = 16'h0001;
endpackage : ppess_pkg

//--- logic/ppess_sync_if.sv
// Carries asynchronous source levels into the synchroniser and back.
// Assumes all levels are sampled on the block clock.
`timescale 1ns/100ps
interface ppess_sync_if;
    import ppess_pkg::*;
    logic [SRC_N-1:0] raw;
    logic [SRC_N-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface : ppess_sync_if

//--- logic/ppess_sync.sv
// Two-flop synchroniser for the external pin and comparator levels.
// Assumes the levels are asynchronous to ref_clk_i.
`timescale 1ns/100ps
module ppess_sync
    import ppess_pkg::*;
(
    input  wire logic    ref_clk_i,
    input  wire logic    rst_i,
    ppess_sync_if.sync_side sif
);
    logic [SRC_N-1:0] meta;
    logic [SRC_N-1:0] stable;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta   <= '0;
            stable <= '0;
        end
        else
        begin
            meta   <= sif.raw;
            stable <= meta;
        end
    end

    assign sif.synced = stable;
endmodule : ppess_sync

//--- logic/ppess_top.sv
// Period and falling-edge event source selection with its time-base counter.
// Assumes a simple strobe register port; pin and comparator levels are asynchronous.
`timescale 1ns/100ps
module ppess_top
    import ppess_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              external_pwm_input_i,
    input  wire logic              comparator1_out_i,
    input  wire logic              comparator2_out_i,
    input  wire logic              comparator3_out_i,
    output logic                   period_event_o,
    output logic                   falling_edge_event_o,
    output logic      [TB_W-1:0]   time_base_counter_o
);
    // ****************************************
    // Synchronisation and edge detection
    // ****************************************
    ppess_sync_if sif ();
    assign sif.raw = {external_pwm_input_i, comparator3_out_i, comparator2_out_i, comparator1_out_i};

    ppess_sync u_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .sif       (sif)
    );

    wire  [SRC_N-1:0] src_rise;

    // One rising-edge detector per source; the previous level resets to the idle low
    // of the synchroniser, so leaving reset never shows an edge by itself
    genvar gi;
    generate
        for (gi = 0; gi < SRC_N; gi++)
        begin : g_edge
            logic prev;

            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    prev <= 1'b0;
                else
                    prev <= sif.synced[gi];
            end

            assign src_rise[gi] = sif.synced[gi] & ~prev;
        end
    endgenerate

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]      period_event_source_enable;
    logic [7:0]      falling_edge_source_enable;
    logic [TB_W-1:0] period_compare_value;
    logic [TB_W-1:0] duty_compare_value;
    logic [TB_W-1:0] time_base_counter;

    // Source enables in the order of the synchronised vector
    function automatic logic [SRC_N-1:0] src_enables(input logic [7:0] reg_val);
        src_enables = {reg_val[BIT_PIN], reg_val[BIT_CMP3], reg_val[BIT_CMP2], reg_val[BIT_CMP1]};
    endfunction : src_enables

    // Byte lane of a 16-bit register as seen on the 8-bit port
    function automatic logic [DATA_W-1:0] byte_lane(input logic [TB_W-1:0] value, input logic upper);
        byte_lane = upper ? value[TB_W-1:DATA_W] : value[DATA_W-1:0];
    endfunction : byte_lane

    wire [SRC_N-1:0] period_src_en = src_enables(period_event_source_enable);
    wire [SRC_N-1:0] fall_src_en   = src_enables(falling_edge_source_enable);

    wire wr_psrc  = wr_i && (addr_i == OFF_PERIOD_SRC);
    wire wr_fsrc  = wr_i && (addr_i == OFF_FALL_SRC);
    wire wr_pr_lo = wr_i && (addr_i == OFF_PERIOD_LO);
    wire wr_pr_hi = wr_i && (addr_i == OFF_PERIOD_HI);
    wire wr_dc_lo = wr_i && (addr_i == OFF_DUTY_LO);
    wire wr_dc_hi = wr_i && (addr_i == OFF_DUTY_HI);

    // ****************************************
    // Event generation
    // ****************************************
    wire tb_match   = (time_base_counter == period_compare_value);
    wire duty_match = (time_base_counter == duty_compare_value);
    wire period_hit = |(src_rise & period_src_en)
                    | (tb_match & period_event_source_enable[BIT_TIMEBASE]);
    wire fall_hit   = |(src_rise & fall_src_en)
                    | (duty_match & falling_edge_source_enable[BIT_TIMEBASE]);

    assign period_event_o       = period_hit;
    assign falling_edge_event_o = fall_hit;

    wire [TB_W-1:0] next_time_base_counter = period_hit ? TB_RESET : time_base_counter + TB_STEP;

    // ****************************************
    // Read mux
    // ****************************************
    logic [DATA_W-1:0] read_sel;
    always_comb
    begin
        case (addr_i)
            OFF_PERIOD_SRC:  read_sel = period_event_source_enable;
            OFF_FALL_SRC:    read_sel = falling_edge_source_enable;
            OFF_PERIOD_LO:   read_sel = byte_lane(period_compare_value, 1'b0);
            OFF_PERIOD_HI:   read_sel = byte_lane(period_compare_value, 1'b1);
            OFF_DUTY_LO:     read_sel = byte_lane(duty_compare_value, 1'b0);
            OFF_DUTY_HI:     read_sel = byte_lane(duty_compare_value, 1'b1);
            OFF_TIMEBASE_LO: read_sel = byte_lane(time_base_counter, 1'b0);
            OFF_TIMEBASE_HI: read_sel = byte_lane(time_base_counter, 1'b1);
            default:         read_sel = 8'h00;
        endcase
    end

    // ****************************************
    // Clocked state
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            period_event_source_enable <= SRC_RESET;
            falling_edge_source_enable <= SRC_RESET;
            period_compare_value       <= PERIOD_RESET;
            duty_compare_value         <= DUTY_RESET;
            time_base_counter          <= TB_RESET;
            rdata_o                    <= 8'h00;
        end
        else
        begin
            // Unimplemented bits are masked so they never store a write
            if (wr_psrc) period_event_source_enable <= wdata_i & SRC_IMPL_MASK;
            if (wr_fsrc) falling_edge_source_enable <= wdata_i & SRC_IMPL_MASK;
            if (wr_pr_lo) period_compare_value[DATA_W-1:0]  <= wdata_i;
            if (wr_pr_hi) period_compare_value[TB_W-1:DATA_W] <= wdata_i;
            if (wr_dc_lo) duty_compare_value[DATA_W-1:0]    <= wdata_i;
            if (wr_dc_hi) duty_compare_value[TB_W-1:DATA_W]   <= wdata_i;
            time_base_counter <= next_time_base_counter;
            rdata_o           <= rd_i ? read_sel : 8'h00;
        end
    end

    assign time_base_counter_o = time_base_counter;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    pin_event_a: assert property (period_event_source_enable[BIT_PIN] && src_rise[SRC_N-1]
        |-> period_event_o ##1 time_base_counter == TB_RESET)
        else $error("pin edge did not end the period");
    cmp_event_a: assert property (|(src_rise[SRC_N-2:0] & period_src_en[SRC_N-2:0])
        |-> period_event_o)
        else $error("comparator edge did not end the period");
    match_event_a: assert property (period_event_source_enable[BIT_TIMEBASE] && tb_match
        |=> time_base_counter == TB_RESET)
        else $error("period match did not clear the counter");
    disabled_quiet_a: assert property (period_event_o
        |-> |(src_rise & period_src_en) || (tb_match && period_event_source_enable[BIT_TIMEBASE]))
        else $error("period event without an enabled source");
    count_run_a: assert property (!period_event_o
        |=> time_base_counter == $past(time_base_counter) + TB_STEP)
        else $error("counter disturbed without a period event");
    multi_src_a: assert property (period_src_en[SRC_N-1] && period_src_en[0]
        && src_rise[0] && !src_rise[SRC_N-1] |-> period_event_o)
        else $error("second enabled source ignored");

    enable_write_a: assert property (wr_psrc
        |=> period_event_source_enable == ($past(wdata_i) & SRC_IMPL_MASK))
        else $error("period source register write lost");
    fall_write_a: assert property (wr_fsrc
        |=> falling_edge_source_enable == ($past(wdata_i) & SRC_IMPL_MASK))
        else $error("falling source register write lost");
    period_write_a: assert property (wr_pr_lo
        |=> period_compare_value[DATA_W-1:0] == $past(wdata_i))
        else $error("period value write lost");
    unimpl_zero_a: assert property (rd_i && addr_i == OFF_PERIOD_SRC
        |=> (rdata_o & ~SRC_IMPL_MASK) == 8'h00 && rdata_o[BIT_PIN] == $past(period_event_source_enable[BIT_PIN]))
        else $error("unimplemented bits read nonzero");
    fall_read_a: assert property (rd_i && addr_i == OFF_FALL_SRC
        |=> rdata_o == $past(falling_edge_source_enable))
        else $error("falling source register read wrong");
    unmapped_read_a: assert property (rd_i && addr_i > OFF_TIMEBASE_HI
        |=> rdata_o == 8'h00)
        else $error("unmapped register read nonzero");
    rdata_idle_a: assert property (!rd_i
        |=> rdata_o == 8'h00)
        else $error("read data outside a read");

    fall_event_a: assert property (|(src_rise & fall_src_en)
        |-> falling_edge_event_o)
        else $error("falling edge source ignored");
    fall_quiet_a: assert property (falling_edge_event_o
        |-> |(src_rise & fall_src_en) || (duty_match && falling_edge_source_enable[BIT_TIMEBASE]))
        else $error("falling event without an enabled source");

    // One check per source, so a failure names the lane whose enable was lost
    generate
        for (gi = 0; gi < SRC_N; gi++)
        begin : g_src_chk
            src_event_a: assert property (src_rise[gi] && period_src_en[gi]
                |=> time_base_counter == TB_RESET)
                else $error("enabled source edge did not clear the counter");
        end
    endgenerate

    pin_period_c:   cover property (period_event_source_enable[BIT_PIN] && src_rise[SRC_N-1]);
    cmp_period_c:   cover property (period_src_en[0] && src_rise[0]);
    match_period_c: cover property (period_event_source_enable[BIT_TIMEBASE] && tb_match);
    fall_event_c:   cover property (falling_edge_event_o);
    multi_src_c:    cover property (period_src_en[SRC_N-1] && period_src_en[0] && src_rise[0] && !src_rise[SRC_N-1]);
endmodule : ppess_top

//--- dv/ppess_src_model.sv
// Far-side model: the external input pin and the three comparator outputs.
// Assumes the bench asks for levels; they move on the falling clock edge, away from the sampling edge.
`timescale 1ns/100ps
module ppess_src_model
(
    input  wire logic       ref_clk_i,
    input  wire logic [3:0] want_i,
    output logic      [3:0] lvl_o
);
    initial lvl_o = 4'h0;
    // Bit 0 pin, bits 1 to 3 comparators 1 to 3
    always @(negedge ref_clk_i) lvl_o <= want_i;
endmodule : ppess_src_model

//--- dv/tb_pwm_period_event_source_select.sv
// Bench for the period event source select block.
// Assumes the source model stands in for the pin and comparators.
`timescale 1ns/100ps
module tb_pwm_period_event_source_select;
    import ppess_pkg::*;
    logic              ref_clk_i;
    logic              rst_i = 1'b1;
    logic              wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = 8'h00, rdata_o, m;
    logic [3:0]        want = 4'h0, lvl;
    logic              pev, fev;
    logic [TB_W-1:0]   tbc;
    logic [7:0]        exp_q[$];
    int                num_errors = 0, n_tests = 0, pc, fc;
    int                seed = 32'hB8BF;
    ppess_src_model i_src (.ref_clk_i(ref_clk_i), .want_i(want), .lvl_o(lvl));
    ppess_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .external_pwm_input_i(lvl[0]), .comparator1_out_i(lvl[1]),
        .comparator2_out_i(lvl[2]), .comparator3_out_i(lvl[3]), .period_event_o(pev),
        .falling_edge_event_o(fev), .time_base_counter_o(tbc));
    // ************************************************************
    // Bus tasks, window counter and report
    // ************************************************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        exp_q.push_back(exp);
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
    endtask : rd
    // Counts both events over n cycles; the counter must be zero after each period event
    task automatic win(input int n);
        logic was;
        pc  = 0;
        fc  = 0;
        was = 1'b0;
        repeat (n)
        begin
            @(negedge ref_clk_i);
            if (was) check("counter", 16'h0000, tbc);
            was = (pev === 1'b1);
            pc += int'(was);
            fc += int'(fev === 1'b1);
        end
    endtask : win
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    always @(posedge ref_clk_i) rd_d <= rd_i;
    always @(negedge ref_clk_i)
    begin
        if (rd_d)
            check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
    end
    // ************************************************************
    // Clock, watchdog and scenarios
    // ************************************************************
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        #200000;
        num_errors++;
        close_out();
    end
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(OFF_PERIOD_SRC, 8'h00);
        m = 8'($random(seed));
        wr(OFF_PERIOD_SRC, m);
        rd(OFF_PERIOD_SRC, m & SRC_IMPL_MASK);
        wr(OFF_FALL_SRC, ~m);
        rd(OFF_FALL_SRC, ~m & SRC_IMPL_MASK);
        rd(OFF_PERIOD_HI, PERIOD_RESET[TB_W-1:DATA_W]);
        wr(4'h9, m);
        rd(4'h9, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            m = (i == 0) ? 8'h80 : 8'(1 << i);
            wr(OFF_PERIOD_SRC, m);
            wr(OFF_FALL_SRC, m);
            want <= 4'(1 << i);
            win(8);
            check("period events", 16'h0001, 16'(pc));
            check("falling events", 16'h0001, 16'(fc));
            want <= 4'h0;
            win(4);
            // Every other pin and comparator source stays enabled, the time base does not, so only a missing mask shows
            wr(OFF_PERIOD_SRC, 8'h8E & ~m);
            wr(OFF_FALL_SRC, 8'h00);
            want <= 4'(1 << i);
            win(8);
            check("disabled source", 16'h0000, 16'(pc));
            want <= 4'h0;
            win(4);
        end
        $display("test single sources done");
        wr(OFF_PERIOD_SRC, 8'h8E);
        wr(OFF_FALL_SRC, 8'h8E);
        want <= 4'hF;
        win(8);
        check("joint period events", 16'h0001, 16'(pc));
        check("joint falling events", 16'h0001, 16'(fc));
        want <= 4'h0;
        win(4);
        // Cmp1 alone, then the pin while cmp1 stays high: each enabled source ends a period on its own
        wr(OFF_PERIOD_SRC, 8'h82);
        wr(OFF_FALL_SRC, 8'h00);
        want <= 4'h2;
        win(8);
        check("cmp1 beside pin", 16'h0001, 16'(pc));
        want <= 4'h3;
        win(8);
        check("pin beside cmp1", 16'h0001, 16'(pc));
        check("falling disabled", 16'h0000, 16'(fc));
        want <= 4'h0;
        win(4);
        $display("test independent sources done");
        wr(OFF_PERIOD_LO, 8'h05);
        wr(OFF_PERIOD_HI, 8'h00);
        wr(OFF_DUTY_LO, 8'h03);
        wr(OFF_FALL_SRC, 8'h01);
        wr(OFF_PERIOD_SRC, 8'h81);
        // Pin event clears a counter that may sit far above the period value
        want <= 4'h1;
        win(6);
        win(42);
        check("match events", 16'h0007, 16'(pc));
        check("duty match events", 16'h0007, 16'(fc));
        rd(OFF_PERIOD_LO, 8'h05);
        $display("test match done");
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(OFF_PERIOD_SRC, 8'h00);
        rd(OFF_FALL_SRC, 8'h00);
        rd(OFF_PERIOD_LO, PERIOD_RESET[DATA_W-1:0]);
        want <= 4'h0;
        repeat (2) @(posedge ref_clk_i);
        $display("test reset done");
        close_out();
    end
endmodule : tb_pwm_period_event_source_select
